// ---- test_tpw_timer.sv ----
// Self-checking bench for the PWM timer.
`timescale 1ns/1ps
module test_tpw_timer;
   import tpw_pkg::*;
   logic clk, rstn, psel, penable, pwrite, cap_one, cap_two, int_wake, run_ext, err;
   logic pready, pslverr, out1, out1_oe, out2, out2_oe, irq, wait_exit, ext_tick;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdata, cnt_a;
   int num_errors = 0;
   int samples_checked = 0;
   tpw_timer tpw_timer_inst (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .CAPTURE_IN_PIN_ONE(cap_one), .CAPTURE_IN_PIN_TWO(cap_two),
      .EXT_TICK_PIN(ext_tick), .INT_WAKE(int_wake), .TIMER_OUT_PIN_ONE(out1),
      .TIMER_OUT_PIN_ONE_OE(out1_oe), .TIMER_OUT_PIN_TWO(out2),
      .TIMER_OUT_PIN_TWO_OE(out2_oe), .TIMER_IRQ(irq), .WAIT_EXIT(wait_exit));
   tpw_pin_model tpw_pin_model_inst (.run_ext(run_ext), .ext_tick(ext_tick));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic close_out();
      $display("mismatches %0d of %0d checks", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; it holds the request until pready is seen at a rising edge.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         check(1'b0, 1'b1);
         close_out();
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Counts settled cycles until pin one shows the level; the bound ends a hang.
   task automatic wait_pin(input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (out1 !== lvl) begin
         @(negedge clk);
         cyc++;
         if (cyc > lim) begin
            check(out1, lvl);
            close_out();
         end
      end
   endtask
   task automatic scn_reset();
      apb(0, ADDR_CTRL_ONE, 0);
      check(rdata, 32'h0);
      apb(0, ADDR_CMP2_HI, 0);
      check(rdata, {24'h0, CMP_RESET[15:8]});
      apb(0, 8'h38, 0);
      check({31'h0, err}, 32'h1);
      check(rdata, 32'h0);
   endtask
   task automatic scn_force();
      apb(1, ADDR_CTRL_TWO, 32'hc0);
      apb(1, ADDR_CTRL_ONE, 32'h1d);
      repeat (3) @(negedge clk);
      check({out1_oe, out1, out2}, 3'b111);
      apb(1, ADDR_CTRL_ONE, 32'h18);
      repeat (3) @(negedge clk);
      check({out1, out2}, 2'b00);
   endtask
   // Pulse and period lengths in clock cycles for one tick rate.
   task automatic pwm_run(input logic [1:0] sel, input int div);
      int hi_len, lo_len;
      apb(1, ADDR_CTRL_TWO, 32'hb0 | {sel, 2'b00});
      wait_pin(1, 5000, hi_len);
      wait_pin(0, 5000, hi_len);
      wait_pin(1, 5000, hi_len);
      wait_pin(0, 5000, hi_len);
      wait_pin(1, 5000, lo_len);
      check(hi_len, (32'h30 - 32'h10) * div);
      check(hi_len + lo_len, (32'h30 + 5) * div);
   endtask
   task automatic scn_pwm();
      apb(1, ADDR_POWER, 0);
      apb(1, ADDR_CMP1_HI, 0);
      apb(1, ADDR_CMP1_LO, 32'h10);
      apb(1, ADDR_CMP2_HI, 0);
      apb(1, ADDR_CMP2_LO, 32'h30);
      apb(1, ADDR_CTRL_ONE, 32'h81);
      pwm_run(TICK_DIV4, 4);
      pwm_run(TICK_DIV2, 2);
      // The far-side tick toggles every 10 ns, so a falling edge comes every 5 clocks.
      run_ext <= 1'b1;
      pwm_run(TICK_EXT, 5);
      run_ext <= 1'b0;
      pwm_run(TICK_DIV8, 8);
      apb(0, ADDR_FLAGS, 0);
      check({rdata[F_CAP1], rdata[F_CMP1], rdata[F_CMP2], irq}, 4'b1001);
      apb(1, ADDR_POWER, 32'h2);
      // The write lands at the access edge, so look once it has settled.
      @(negedge clk);
      check(wait_exit, 1'b1);
      apb(1, ADDR_POWER, 32'h4);
      @(negedge clk);
      check(irq, 1'b0);
      apb(1, ADDR_POWER, 0);
      apb(0, ADDR_FLAGS, 0);
      apb(0, ADDR_CAP1_LO, 0);
      apb(0, ADDR_FLAGS, 0);
      check({rdata[F_CAP1], irq}, 2'b00);
   endtask
   // A lone high-byte write must hold off compare two until the low byte lands.
   task automatic scn_halfwrite();
      int n, falls;
      wait_pin(1, 1000, n);
      apb(1, ADDR_CMP2_HI, 0);
      falls = 0;
      repeat (600) begin
         @(negedge clk);
         falls += (out1 !== 1'b1);
      end
      check(falls, 0);
      apb(1, ADDR_CMP2_LO, 32'h30);
      apb(1, ADDR_CNT_LO, 0);
      wait_pin(0, 600, n);
      check(out1, 1'b0);
   endtask
   task automatic scn_level();
      int n, moves;
      apb(1, ADDR_CTRL_ONE, 32'h05);
      wait_pin(1, 1000, n);
      moves = 0;
      repeat (1000) begin
         @(negedge clk);
         moves += (out1 !== 1'b1);
      end
      check(moves, 0);
   endtask
   task automatic scn_halt();
      apb(1, ADDR_CTRL_TWO, 32'h04);
      apb(1, ADDR_POWER, 32'h1);
      apb(0, ADDR_CNT_LO, 0);
      cnt_a = rdata;
      repeat (20) @(posedge clk);
      apb(0, ADDR_CNT_LO, 0);
      check(rdata, cnt_a);
      int_wake <= 1'b1;
      @(posedge clk);
      int_wake <= 1'b0;
      repeat (20) @(posedge clk);
      apb(0, ADDR_CNT_LO, 0);
      check(rdata == cnt_a, 1'b0);
   endtask
   initial begin
      {rstn, psel, penable, pwrite, cap_one, cap_two, int_wake, run_ext} = 8'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      scn_reset();
      scn_force();
      scn_pwm();
      scn_halfwrite();
      scn_level();
      scn_halt();
      close_out();
   end
endmodule // test_tpw_timer

// ---- tpw_pin_model.sv ----
// Model of the far-side pin driver that supplies the external tick.
`timescale 1ns/1ps
module tpw_pin_model (
   input wire logic run_ext,
   output logic ext_tick
);
   // The tick stands still unless asked to run, so no stray count edges reach the timer.
   initial begin
      ext_tick = 1'b0;
      // Offset keeps every toggle away from a rising clock edge.
      #1;
      forever begin
         #10;
         if (run_ext) begin
            ext_tick = !ext_tick;
         end
      end
   end
endmodule // tpw_pin_model

// ---- tpw_pkg.sv ----
// Package with register map, field positions, reset values and timing constants of the PWM timer.
package tpw_pkg;
   // Register byte addresses on the APB bus, one aligned word each.
   localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
   localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_CAP1_HI = 8'h0c;
   localparam logic [7:0] ADDR_CAP1_LO = 8'h10;
   localparam logic [7:0] ADDR_CMP1_HI = 8'h14;
   localparam logic [7:0] ADDR_CMP1_LO = 8'h18;
   localparam logic [7:0] ADDR_CMP2_HI = 8'h1c;
   localparam logic [7:0] ADDR_CMP2_LO = 8'h20;
   localparam logic [7:0] ADDR_CNT_HI = 8'h24;
   localparam logic [7:0] ADDR_CNT_LO = 8'h28;
   localparam logic [7:0] ADDR_CAP2_HI = 8'h2c;
   localparam logic [7:0] ADDR_CAP2_LO = 8'h30;
   localparam logic [7:0] ADDR_POWER = 8'h34;
   // Control register one fields.
   localparam int C1_CAP_IE = 7;
   localparam int C1_CMP_IE = 6;
   localparam int C1_OVF_IE = 5;
   localparam int C1_FORCE2 = 4;
   localparam int C1_FORCE1 = 3;
   localparam int C1_LVL2 = 2;
   localparam int C1_EDGE1 = 1;
   localparam int C1_LVL1 = 0;
   // Control register two fields.
   localparam int C2_OUT1_EN = 7;
   localparam int C2_OUT2_EN = 6;
   localparam int C2_PULSE = 5;
   localparam int C2_PWM = 4;
   localparam int C2_TICK_HI = 3;
   localparam int C2_TICK_LO = 2;
   localparam int C2_EDGE2 = 1;
   localparam int C2_EXT_EDGE = 0;
   // Flag register fields.
   localparam int F_CAP1 = 7;
   localparam int F_CMP1 = 6;
   localparam int F_OVF = 5;
   localparam int F_CAP2 = 4;
   localparam int F_CMP2 = 3;
   // Reset and reload values.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] CNT_RESET = 16'hfffc;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   // Tick source selections and prescaler limits (count minus one).
   localparam logic [1:0] TICK_DIV4 = 2'b00;
   localparam logic [1:0] TICK_DIV2 = 2'b01;
   localparam logic [1:0] TICK_DIV8 = 2'b10;
   localparam logic [1:0] TICK_EXT = 2'b11;
   localparam logic [2:0] PRE_LAST2 = 3'h1;
   localparam logic [2:0] PRE_LAST4 = 3'h3;
   localparam logic [2:0] PRE_LAST8 = 3'h7;
   // Power control bits in the power register.
   localparam int P_HALT = 0;
   localparam int P_WAIT = 1;
   localparam int P_GMASK = 2;
   // Halt wake-up state machine.
   typedef enum logic [1:0] {
      TPW_RUN  = 2'b01,
      TPW_HALT = 2'b10
   } tpw_state_t;
endpackage

// ---- tpw_timer.sv ----
// PWM timer with compare, capture, flags, low power handling and an APB register slave.
//
// Operation
// (RL1) PWM: pin one takes level one on compare-one match, level two on compare-two.
// (RL2) PWM: compare-two match reloads counter with FFFCh.
// (RL3) Level one high, level two low gives pulse of compare two minus one.
// (RL4) Equal levels keep pin one constant.
// (RL5) Period equals compare value plus five ticks.
// (RL6) Writing high compare byte suppresses compare until low byte written.
// (RL7) PWM mode never sets compare flags.
// (RL8) PWM: compare-two match sets capture flag one; interrupt if enabled, unmasked.
// (RL9) PWM disconnects capture input one; capture two still works.
// (RL10) PWM and single-pulse both set means PWM only.
// (RL11) Wait leaves timer running; enabled interrupt ends wait.
// (RL12) Halt freezes counter; interrupt wake resumes, reset restarts.
// (RL13) Capture edge in halt arms capture, performed on interrupt wake.
// (RL14) One shared interrupt, per-event enables and global mask; no halt wake.
// (RL15) Control register one resets to 00h with the given bit order.
// (RL16) Capture enable gates interrupts from either capture flag.
// (RL17) Compare enable gates interrupts from either compare flag.
// (RL18) Overflow enable gates the overflow flag interrupt.
// (RL19) Force two copies level two onto pin two when enabled.
// (RL20) Force one copies level one onto pin one when enabled.
// (RL21) Level two drives pin two on match, pin one in pulse modes.
// (RL22) Capture edge one: zero falling, one rising.
// (RL23) Tick select: 00 div4, 01 div2, 10 div8, 11 external.
// (RL24) Pin one carries waveform only while its output enable is set.
// (RL25) Flag cleared by status read then capture-one low byte access.
// (RL26) Compare once per tick; half-written compare never matches.
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module tpw_timer
   import tpw_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic CAPTURE_IN_PIN_ONE,
   input wire logic CAPTURE_IN_PIN_TWO,
   input wire logic EXT_TICK_PIN,
   input wire logic INT_WAKE,
   output logic TIMER_OUT_PIN_ONE,
   output logic TIMER_OUT_PIN_ONE_OE,
   output logic TIMER_OUT_PIN_TWO,
   output logic TIMER_OUT_PIN_TWO_OE,
   output logic TIMER_IRQ,
   output logic WAIT_EXIT
);

   // Registers and state.
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [2:0] power_reg;
   logic [15:0] cmp1_reg;
   logic [15:0] cmp2_reg;
   logic cmp1_hold_reg;
   logic cmp2_hold_reg;
   logic [15:0] cnt_reg;
   logic [15:0] cap1_reg;
   logic [15:0] cap2_reg;
   logic [4:0] flag_reg;
   logic [4:0] flag_seen_reg;
   logic [2:0] pre_reg;
   logic out1_reg;
   logic out2_reg;
   logic [7:0] rdata_reg;
   logic [2:0] cap1_sync_reg;
   logic [2:0] cap2_sync_reg;
   logic [2:0] ext_sync_reg;
   logic arm1_reg;
   logic arm2_reg;
   tpw_state_t state_reg;
   tpw_state_t state_next;

   // Synchronise pin inputs; only the second and third stages are read by logic.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cap1_sync_reg <= 3'h0;
         cap2_sync_reg <= 3'h0;
         ext_sync_reg <= 3'h0;
      end else begin
         cap1_sync_reg <= {cap1_sync_reg[1:0], CAPTURE_IN_PIN_ONE};
         cap2_sync_reg <= {cap2_sync_reg[1:0], CAPTURE_IN_PIN_TWO};
         ext_sync_reg <= {ext_sync_reg[1:0], EXT_TICK_PIN};
      end
   end

   // Edge detect on synchronised levels; the edge bit picks rising or falling.
   function automatic logic edge_hit(input logic [2:0] s, input logic rising);
      edge_hit = rising ? (s[1] & ~s[2]) : (~s[1] & s[2]);
   endfunction

   // Mode decode: PWM wins over single pulse.
   wire pwm_mode = ctrl2_reg[C2_PWM]; // [RL10]
   wire pulse_mode = ctrl2_reg[C2_PULSE] & ~pwm_mode; // [RL10]
   wire halted = (state_reg == TPW_HALT);
   wire [1:0] tick_sel = ctrl2_reg[C2_TICK_HI:C2_TICK_LO];

   // Tick generation: the prescaler runs only out of halt.
   wire [2:0] pre_last = (tick_sel == TICK_DIV2) ? PRE_LAST2 :
                         (tick_sel == TICK_DIV8) ? PRE_LAST8 : PRE_LAST4; // [RL23]
   wire ext_tick = edge_hit(ext_sync_reg, ctrl2_reg[C2_EXT_EDGE]);
   wire tick = ~halted & ((tick_sel == TICK_EXT) ? ext_tick : (pre_reg == pre_last)); // [RL23]

   // Compare once per tick; a held (half-written) register never matches.
   wire match1 = tick & ~cmp1_hold_reg & (cnt_reg == cmp1_reg); // [RL6] [RL26]
   wire match2 = tick & ~cmp2_hold_reg & (cnt_reg == cmp2_reg); // [RL6] [RL26]
   wire overflow = tick & (cnt_reg == CNT_MAX);

   // Capture edges; pin one is cut off from the timer in PWM mode.
   wire edge1 = edge_hit(cap1_sync_reg, ctrl1_reg[C1_EDGE1]) & ~pwm_mode; // [RL9] [RL22]
   wire edge2 = edge_hit(cap2_sync_reg, ctrl2_reg[C2_EDGE2]); // [RL9]
   wire wake = halted & INT_WAKE;
   wire cap1_evt = (~halted & edge1) | (wake & arm1_reg); // [RL13]
   wire cap2_evt = (~halted & edge2) | (wake & arm2_reg); // [RL13]

   // Counter next value; compare two reloads in PWM so period is compare plus five ticks.
   wire [15:0] cnt_inc = cnt_reg + 16'h0001;
   wire [15:0] cnt_next = (pwm_mode & match2) ? CNT_RESET : cnt_inc; // [RL2] [RL5]

   // Bus decode: zero wait states, access phase completes at once.
   wire acc = PSEL & PENABLE;
   wire wr = acc & PWRITE;
   wire rd = acc & ~PWRITE;
   wire addr_ok = (PADDR[1:0] == 2'b00) && (PADDR <= ADDR_POWER);
   wire flags_rd = rd & (PADDR == ADDR_FLAGS);
   wire cap1_lo_acc = acc & (PADDR == ADDR_CAP1_LO);
   wire cap2_lo_acc = acc & (PADDR == ADDR_CAP2_LO);
   wire cmp1_lo_acc = acc & (PADDR == ADDR_CMP1_LO);
   wire cmp2_lo_acc = acc & (PADDR == ADDR_CMP2_LO);
   wire cnt_lo_acc = acc & (PADDR == ADDR_CNT_LO);
   wire cnt_lo_wr = wr & (PADDR == ADDR_CNT_LO);
   wire [4:0] flag_clr = flag_seen_reg & {cap1_lo_acc, cmp1_lo_acc, cnt_lo_acc,
                                          cap2_lo_acc, cmp2_lo_acc}; // [RL25]
   // Hardware events; in PWM compare flags never set and compare two sets capture one.
   wire [4:0] flag_set = {cap1_evt | (pwm_mode & match2), // [RL8]
                          match1 & ~pwm_mode, overflow, cap2_evt, // [RL7]
                          match2 & ~pwm_mode}; // [RL7]
   wire [15:0] cap_src = halted ? cnt_reg : cnt_reg;
   wire [7:0] flag_byte = {flag_reg, 3'h0};

   // Read mux.
   wire [7:0] rd_mux =
      (PADDR == ADDR_CTRL_ONE) ? ctrl1_reg :
      (PADDR == ADDR_CTRL_TWO) ? ctrl2_reg :
      (PADDR == ADDR_FLAGS) ? flag_byte :
      (PADDR == ADDR_CAP1_HI) ? cap1_reg[15:8] :
      (PADDR == ADDR_CAP1_LO) ? cap1_reg[7:0] :
      (PADDR == ADDR_CMP1_HI) ? cmp1_reg[15:8] :
      (PADDR == ADDR_CMP1_LO) ? cmp1_reg[7:0] :
      (PADDR == ADDR_CMP2_HI) ? cmp2_reg[15:8] :
      (PADDR == ADDR_CMP2_LO) ? cmp2_reg[7:0] :
      (PADDR == ADDR_CNT_HI) ? cnt_reg[15:8] :
      (PADDR == ADDR_CNT_LO) ? cnt_reg[7:0] :
      (PADDR == ADDR_CAP2_HI) ? cap2_reg[15:8] :
      (PADDR == ADDR_CAP2_LO) ? cap2_reg[7:0] :
      (PADDR == ADDR_POWER) ? {5'h00, power_reg} : 8'h00;

   // Interrupt: per-event enables, global mask; one request shared by all flag groups.
   wire irq_raw = (ctrl1_reg[C1_CAP_IE] & (flag_reg[F_CAP1-3] | flag_reg[F_CAP2-3])) | // [RL16]
                  (ctrl1_reg[C1_CMP_IE] & (flag_reg[F_CMP1-3] | flag_reg[F_CMP2-3])) | // [RL17]
                  (ctrl1_reg[C1_OVF_IE] & flag_reg[F_OVF-3]); // [RL18]
   assign TIMER_IRQ = irq_raw & ~power_reg[P_GMASK]; // [RL14]
   assign WAIT_EXIT = TIMER_IRQ & power_reg[P_WAIT]; // [RL11]

   // Pin outputs and bus answers.
   assign TIMER_OUT_PIN_ONE = out1_reg;
   assign TIMER_OUT_PIN_ONE_OE = ctrl2_reg[C2_OUT1_EN]; // [RL24]
   assign TIMER_OUT_PIN_TWO = out2_reg;
   assign TIMER_OUT_PIN_TWO_OE = ctrl2_reg[C2_OUT2_EN];
   assign PREADY = 1'b1;
   assign PSLVERR = acc & ~addr_ok;
   assign PRDATA = {24'h000000, rdata_reg};

   // Halt state: entered by software, left only by an outside wake, never by timer events.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         TPW_RUN: begin
            if (power_reg[P_HALT]) begin
               state_next = TPW_HALT;
            end
         end
         TPW_HALT: begin
            if (INT_WAKE) begin
               state_next = TPW_RUN; // [RL12] [RL14]
            end
         end
         default: state_next = TPW_RUN;
      endcase
   end

   // Control registers; halt bit drops on wake so software sees it left.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctrl1_reg <= CTRL_RESET; // [RL15]
         ctrl2_reg <= CTRL_RESET;
         power_reg <= 3'h0;
         state_reg <= TPW_RUN;
      end else begin
         state_reg <= state_next;
         if (wr & (PADDR == ADDR_CTRL_ONE)) ctrl1_reg <= PWDATA[7:0]; // [RL15]
         if (wr & (PADDR == ADDR_CTRL_TWO)) ctrl2_reg <= PWDATA[7:0];
         if (wr & (PADDR == ADDR_POWER)) begin
            power_reg <= PWDATA[2:0];
         end else if (wake) begin
            power_reg[P_HALT] <= 1'b0;
            power_reg[P_WAIT] <= 1'b0;
         end else if (WAIT_EXIT) begin
            power_reg[P_WAIT] <= 1'b0; // [RL11]
         end
      end
   end

   // Compare registers: high byte write holds the compare until the low byte.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cmp1_reg <= CMP_RESET;
         cmp2_reg <= CMP_RESET;
         cmp1_hold_reg <= 1'b0;
         cmp2_hold_reg <= 1'b0;
      end else begin
         if (wr & (PADDR == ADDR_CMP1_HI)) begin
            cmp1_reg[15:8] <= PWDATA[7:0];
            cmp1_hold_reg <= 1'b1; // [RL6]
         end
         if (wr & cmp1_lo_acc) begin
            cmp1_reg[7:0] <= PWDATA[7:0];
            cmp1_hold_reg <= 1'b0; // [RL6]
         end
         if (wr & (PADDR == ADDR_CMP2_HI)) begin
            cmp2_reg[15:8] <= PWDATA[7:0];
            cmp2_hold_reg <= 1'b1; // [RL6]
         end
         if (wr & cmp2_lo_acc) begin
            cmp2_reg[7:0] <= PWDATA[7:0];
            cmp2_hold_reg <= 1'b0; // [RL6]
         end
      end
   end

   // Prescaler and counter; frozen in halt, a counter low-byte write restarts from the reset value.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pre_reg <= 3'h0;
         cnt_reg <= CNT_RESET; // [RL12]
      end else begin
         if (!halted) pre_reg <= (pre_reg >= pre_last) ? 3'h0 : pre_reg + 3'h1; // [RL12]
         if (cnt_lo_wr) begin
            cnt_reg <= CNT_RESET;
         end else if (tick) begin
            cnt_reg <= cnt_next; // [RL2] [RL11]
         end
      end
   end

   // Captures and halt arming; a capture in halt waits for the wake to store the count.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         cap1_reg <= 16'h0000;
         cap2_reg <= 16'h0000;
         arm1_reg <= 1'b0;
         arm2_reg <= 1'b0;
      end else begin
         if (cap1_evt) cap1_reg <= cap_src; // [RL13]
         if (cap2_evt) cap2_reg <= cap_src; // [RL9]
         if (wake) begin
            arm1_reg <= 1'b0;
            arm2_reg <= 1'b0;
         end else if (halted) begin
            if (edge1) arm1_reg <= 1'b1; // [RL13]
            if (edge2) arm2_reg <= 1'b1; // [RL13]
         end
      end
   end

   // Flags: status read records set flags; the low byte access clears them; set wins.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         flag_reg <= 5'h00;
         flag_seen_reg <= 5'h00;
      end else begin
         flag_reg <= (flag_reg & ~flag_clr) | flag_set; // [RL25] [RL8]
         if (flags_rd) begin
            flag_seen_reg <= flag_reg; // [RL25]
         end else begin
            flag_seen_reg <= flag_seen_reg & ~flag_clr;
         end
      end
   end

   // Output levels. In PWM the pin follows the two compare levels; force is ignored there.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         out1_reg <= 1'b0;
         out2_reg <= 1'b0;
      end else if (pwm_mode) begin
         if (match2) begin
            out1_reg <= ctrl1_reg[C1_LVL2]; // [RL1] [RL3] [RL4] [RL21]
         end else if (match1) begin
            out1_reg <= ctrl1_reg[C1_LVL1]; // [RL1] [RL3] [RL4]
         end
      end else if (pulse_mode) begin
         if (cap1_evt) out1_reg <= ctrl1_reg[C1_LVL2]; // [RL21]
         else if (match1) out1_reg <= ctrl1_reg[C1_LVL1];
      end else begin
         if (match1 | ctrl1_reg[C1_FORCE1]) out1_reg <= ctrl1_reg[C1_LVL1]; // [RL20]
         if (match2 | ctrl1_reg[C1_FORCE2]) out2_reg <= ctrl1_reg[C1_LVL2]; // [RL19] [RL21]
      end
   end

   // Registered read data, taken during the setup phase.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_reg <= 8'h00;
      end else if (PSEL & ~PENABLE) begin
         rdata_reg <= rd_mux;
      end
   end

endmodule // tpw_timer

// ---- tpw_timer_monitor.sv ----
// Checker of the PWM timer behaviour seen at its ports.
`timescale 1ns/1ps
module tpw_timer_chk
   import tpw_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PSLVERR,
   input wire logic TIMER_OUT_PIN_ONE,
   input wire logic TIMER_OUT_PIN_ONE_OE,
   input wire logic TIMER_IRQ,
   input wire logic WAIT_EXIT
);
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   // Bus phase decodes shared by the properties.
   wire wr_en = PSEL && PENABLE && PWRITE;
   wire rd_en = PSEL && PENABLE && !PWRITE;
   wire wr_c2 = wr_en && PADDR == ADDR_CTRL_TWO;
   // Shadow copies of both control registers, so outputs are judged against settings.
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         c1_reg <= 8'h00;
         c2_reg <= 8'h00;
      end else if (wr_en && PADDR == ADDR_CTRL_ONE) begin
         c1_reg <= PWDATA[7:0];
      end else if (wr_c2) begin
         c2_reg <= PWDATA[7:0];
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   sequence s_force_one;
      wr_en && PADDR == ADDR_CTRL_ONE && PWDATA[C1_FORCE1];
   endsequence
   sequence s_plain_mode;
      c2_reg[C2_OUT1_EN] && !c2_reg[C2_PWM] && !c2_reg[C2_PULSE];
   endsequence
   a_slverr_phase: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error response outside access phase");
   a_oe_follows: assert property ($changed(TIMER_OUT_PIN_ONE_OE) |-> $past(wr_c2))
      else $error("pin one enable moved without a control write");
   a_ctrl1_readback: assert property (rd_en && PADDR == ADDR_CTRL_ONE |-> PRDATA == {24'h0, c1_reg})
      else $error("control one readback differs");
   a_upper_zero: assert property (rd_en |-> PRDATA[31:8] == 24'h0)
      else $error("upper read data not zero");
   a_pwm_no_cmp: assert property (rd_en && PADDR == ADDR_FLAGS && c2_reg[C2_PWM]
      |-> !PRDATA[F_CMP1] && !PRDATA[F_CMP2])
      else $error("compare flag set in pwm mode");
   a_irq_gated: assert property (TIMER_IRQ |-> c1_reg[7:5] != 3'b000)
      else $error("interrupt with every enable clear");
   a_wait_needs_irq: assert property (WAIT_EXIT |-> TIMER_IRQ)
      else $error("wait exit without interrupt");
   a_force_one: assert property (s_force_one ##0 s_plain_mode ##1 1'b1
      |-> ##[0:2] TIMER_OUT_PIN_ONE == c1_reg[C1_LVL1])
      else $error("forced level not on pin one");
endmodule // tpw_timer_chk

bind tpw_timer tpw_timer_chk tpw_timer_chk_inst (.CLK, .RSTN, .PSEL, .PENABLE, .PWRITE,
   .PADDR, .PWDATA, .PRDATA, .PSLVERR, .TIMER_OUT_PIN_ONE, .TIMER_OUT_PIN_ONE_OE,
   .TIMER_IRQ, .WAIT_EXIT);
